//--- src/gfm_monitor_regs.vh
// register offsets, field positions, reset values and timing counts of the switch health monitor
`ifndef GFM_MONITOR_REGS_VH
`define GFM_MONITOR_REGS_VH

`define GFM_ADDR_W          12
`define GFM_OFF_CTRL        12'h000
`define GFM_OFF_OT_TRIP     12'h004
`define GFM_OFF_OT_HYST     12'h008
`define GFM_OFF_STATUS      12'h00C
`define GFM_OFF_EVENTS      12'h010
`define GFM_OFF_TEMP_LO     12'h014
`define GFM_OFF_TEMP_HI     12'h018

`define GFM_CTRL_RST        6'h00
`define GFM_OT_TRIP_RST     8'hAF
`define GFM_OT_HYST_RST     8'h14

`define GFM_FLD_FAULT       0
`define GFM_FLD_OC          8
`define GFM_FLD_OT          16
`define GFM_FLD_GROUP       24

`define GFM_PCLK_HZ         50000000
`define GFM_TEMP_FREQ_HZ    9000
`define GFM_PWM_PERIOD_CYC  (`GFM_PCLK_HZ / `GFM_TEMP_FREQ_HZ)

`define GFM_TEMP_LOW_C      25
`define GFM_TEMP_SPAN_C     125
`define GFM_DUTY_LOW_PM     30
`define GFM_DUTY_HIGH_PM    820
`define GFM_PM_FULL         1000

`endif

//--- src/gfm_and3.v
// three-input wired-and merge of active-low switch reports
module gfm_and3 (
	input  wire [2:0] report_n,
	output wire       group_n
);

	assign group_n = &report_n; // [R2]

endmodule

//--- src/gfm_switch.v
// one power switch: fault detection, overtemperature hysteresis and duty-cycle temperature pin
`include "gfm_monitor_regs.vh"

module gfm_switch #(
	parameter PERIOD = `GFM_PWM_PERIOD_CYC
) (
	input  wire       pclk,
	input  wire       presetn,
	input  wire [7:0] junction_temp,
	input  wire       overcurrent_guard,
	input  wire       short_circuit_guard,
	input  wire       supply_undervolt_lockout,
	input  wire       fault_force,
	input  wire [7:0] ot_trip,
	input  wire [7:0] ot_hyst,
	output reg        fault_n_reg,
	output reg        overcurrent_n_reg,
	output reg        temp_pin_reg,
	output reg        ot_active_reg
);

	localparam [31:0] PERIOD_W = PERIOD;
	localparam [31:0] SLOPE    = `GFM_DUTY_HIGH_PM - `GFM_DUTY_LOW_PM;
	localparam [31:0] BASE     = `GFM_DUTY_LOW_PM * `GFM_TEMP_SPAN_C;
	localparam [31:0] DENOM    = `GFM_PM_FULL * `GFM_TEMP_SPAN_C;
	localparam [31:0] T_LOW    = `GFM_TEMP_LOW_C;

	reg  [31:0] phase_reg;
	reg  [31:0] high_reg;
	reg  [31:0] duty_num;
	reg  [31:0] high_next;
	wire [31:0] temp_w = {24'h000000, junction_temp};
	wire        ot_set = junction_temp >= ot_trip;
	wire        ot_clr = ({1'b0, junction_temp} + {1'b0, ot_hyst}) < {1'b0, ot_trip};

	// duty grows linearly with temperature, with no ceiling at 150 C
	always @* begin
		if (temp_w >= T_LOW) begin
			duty_num = BASE + (temp_w - T_LOW) * SLOPE; // [R5] [R6]
		end else if ((T_LOW - temp_w) * SLOPE < BASE) begin
			duty_num = BASE - (T_LOW - temp_w) * SLOPE;
		end else begin
			duty_num = 32'h00000000;
		end
		high_next = (PERIOD_W * duty_num) / DENOM; // [R5]
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg         <= 32'h00000000;
			high_reg          <= 32'h00000000;
			ot_active_reg     <= 1'b0;
			fault_n_reg       <= 1'b1;
			overcurrent_n_reg <= 1'b1;
			temp_pin_reg      <= 1'b0;
		end else begin
			// fixed-rate carrier; duty only reloads at a period boundary so no runt pulses
			if (phase_reg >= PERIOD_W - 32'h00000001) begin
				phase_reg <= 32'h00000000; // [R4]
				high_reg  <= high_next;
			end else begin
				phase_reg <= phase_reg + 32'h00000001;
			end
			if (!ot_active_reg && ot_set) begin
				ot_active_reg <= 1'b1;
			end else if (ot_active_reg && ot_clr) begin
				ot_active_reg <= 1'b0; // [R8]
			end
			fault_n_reg       <= ~(overcurrent_guard | short_circuit_guard | supply_undervolt_lockout |
			                       ot_active_reg | fault_force); // [R1]
			overcurrent_n_reg <= ~(overcurrent_guard | short_circuit_guard); // [R1]
			if (ot_active_reg) begin
				temp_pin_reg <= 1'b1; // [R7]
			end else begin
				temp_pin_reg <= phase_reg < high_reg; // [R4] [R5]
			end
		end
	end

endmodule

//--- src/gfm_monitor.v
// six-switch inverter health block: fault groups, temperature pulse trains and apb registers
// What this block and the controller do
// [R1] each switch flags overcurrent, short, overtemp, undervolt
// [R2] three-input and merges each side's reports
// [R3] controller watches four group signals separately
// [R4] temperature pin pulses at fixed nine kilohertz
// [R5] duty three percent at 25, eighty-two at 150
// [R6] duty keeps rising linearly above 150 C
// [R7] overtemperature holds the temperature pin high
// [R8] overtemperature clears only below trip minus hysteresis
// [R9] only phase v temperatures reach the controller
// [R10] controller converts averaged level to degrees
// [R11] controller calibrates and oversamples the level
// [R12] decoder flags overtemp on long high level
`include "gfm_monitor_regs.vh"

module gfm_monitor #(
	parameter PWM_PERIOD = `GFM_PWM_PERIOD_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	input  wire [47:0] junction_temp,
	input  wire [5:0]  overcurrent_guard,
	input  wire [5:0]  short_circuit_guard,
	input  wire [5:0]  supply_undervolt_lockout,
	output wire [5:0]  switch_fault_n,
	output wire [5:0]  switch_overcurrent_out_n,
	output wire [5:0]  temp_pin,
	output wire        phase_v_upper_temp,
	output wire        phase_v_lower_temp,
	output wire        top_group_fault_n,
	output wire        bottom_group_fault_n,
	output wire        top_group_overcurrent_n,
	output wire        bottom_group_overcurrent_n
);

	// switch index: 0..2 upper side of phases u, v, w; 3..5 lower side
	localparam V_UPPER = 1;
	localparam V_LOWER = 4;

	reg  [5:0]  ctrl_reg;
	reg  [7:0]  ot_trip_reg;
	reg  [7:0]  ot_hyst_reg;
	reg  [5:0]  ev_fault_reg;
	reg  [5:0]  ev_oc_reg;
	reg  [5:0]  ev_ot_reg;
	reg  [5:0]  fault_d_reg;
	reg  [5:0]  oc_d_reg;
	reg  [5:0]  ot_d_reg;
	reg  [31:0] rd_next;
	reg         err_next;
	reg  [5:0]  ev_fault_next;
	reg  [5:0]  ev_oc_next;
	reg  [5:0]  ev_ot_next;

	wire [5:0]  fault_n_w;
	wire [5:0]  oc_n_w;
	wire [5:0]  ot_w;
	wire [5:0]  fault_w = ~fault_n_w;
	wire [5:0]  oc_w    = ~oc_n_w;
	wire [3:0]  group_w;
	wire        setup   = psel & ~penable;
	wire        wr_acc  = psel & penable & pwrite;
	wire [5:0]  clr_w1c = (wr_acc && paddr == `GFM_OFF_EVENTS) ? 6'h3F : 6'h00;

	// each switch keeps its own detection and temperature pin; trip and margin shared by all six
	gfm_switch #(
		.PERIOD(PWM_PERIOD)
	) u_sw_upper_u (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.junction_temp           (junction_temp[7:0]),
		.overcurrent_guard       (overcurrent_guard[0]),
		.short_circuit_guard     (short_circuit_guard[0]),
		.supply_undervolt_lockout(supply_undervolt_lockout[0]),
		.fault_force             (ctrl_reg[0]),
		.ot_trip                 (ot_trip_reg),
		.ot_hyst                 (ot_hyst_reg),
		.fault_n_reg             (fault_n_w[0]),
		.overcurrent_n_reg       (oc_n_w[0]),
		.temp_pin_reg            (temp_pin[0]),
		.ot_active_reg           (ot_w[0])
	);

	gfm_switch #(
		.PERIOD(PWM_PERIOD)
	) u_sw_upper_v (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.junction_temp           (junction_temp[15:8]),
		.overcurrent_guard       (overcurrent_guard[1]),
		.short_circuit_guard     (short_circuit_guard[1]),
		.supply_undervolt_lockout(supply_undervolt_lockout[1]),
		.fault_force             (ctrl_reg[1]),
		.ot_trip                 (ot_trip_reg),
		.ot_hyst                 (ot_hyst_reg),
		.fault_n_reg             (fault_n_w[1]),
		.overcurrent_n_reg       (oc_n_w[1]),
		.temp_pin_reg            (temp_pin[1]),
		.ot_active_reg           (ot_w[1])
	);

	gfm_switch #(
		.PERIOD(PWM_PERIOD)
	) u_sw_upper_w (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.junction_temp           (junction_temp[23:16]),
		.overcurrent_guard       (overcurrent_guard[2]),
		.short_circuit_guard     (short_circuit_guard[2]),
		.supply_undervolt_lockout(supply_undervolt_lockout[2]),
		.fault_force             (ctrl_reg[2]),
		.ot_trip                 (ot_trip_reg),
		.ot_hyst                 (ot_hyst_reg),
		.fault_n_reg             (fault_n_w[2]),
		.overcurrent_n_reg       (oc_n_w[2]),
		.temp_pin_reg            (temp_pin[2]),
		.ot_active_reg           (ot_w[2])
	);

	gfm_switch #(
		.PERIOD(PWM_PERIOD)
	) u_sw_lower_u (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.junction_temp           (junction_temp[31:24]),
		.overcurrent_guard       (overcurrent_guard[3]),
		.short_circuit_guard     (short_circuit_guard[3]),
		.supply_undervolt_lockout(supply_undervolt_lockout[3]),
		.fault_force             (ctrl_reg[3]),
		.ot_trip                 (ot_trip_reg),
		.ot_hyst                 (ot_hyst_reg),
		.fault_n_reg             (fault_n_w[3]),
		.overcurrent_n_reg       (oc_n_w[3]),
		.temp_pin_reg            (temp_pin[3]),
		.ot_active_reg           (ot_w[3])
	);

	gfm_switch #(
		.PERIOD(PWM_PERIOD)
	) u_sw_lower_v (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.junction_temp           (junction_temp[39:32]),
		.overcurrent_guard       (overcurrent_guard[4]),
		.short_circuit_guard     (short_circuit_guard[4]),
		.supply_undervolt_lockout(supply_undervolt_lockout[4]),
		.fault_force             (ctrl_reg[4]),
		.ot_trip                 (ot_trip_reg),
		.ot_hyst                 (ot_hyst_reg),
		.fault_n_reg             (fault_n_w[4]),
		.overcurrent_n_reg       (oc_n_w[4]),
		.temp_pin_reg            (temp_pin[4]),
		.ot_active_reg           (ot_w[4])
	);

	gfm_switch #(
		.PERIOD(PWM_PERIOD)
	) u_sw_lower_w (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.junction_temp           (junction_temp[47:40]),
		.overcurrent_guard       (overcurrent_guard[5]),
		.short_circuit_guard     (short_circuit_guard[5]),
		.supply_undervolt_lockout(supply_undervolt_lockout[5]),
		.fault_force             (ctrl_reg[5]),
		.ot_trip                 (ot_trip_reg),
		.ot_hyst                 (ot_hyst_reg),
		.fault_n_reg             (fault_n_w[5]),
		.overcurrent_n_reg       (oc_n_w[5]),
		.temp_pin_reg            (temp_pin[5]),
		.ot_active_reg           (ot_w[5])
	);

	assign switch_fault_n           = fault_n_w;
	assign switch_overcurrent_out_n = oc_n_w;

	// only the phase v pair is routed out to the controller
	assign phase_v_upper_temp = temp_pin[V_UPPER]; // [R9]
	assign phase_v_lower_temp = temp_pin[V_LOWER]; // [R9]

	gfm_and3 u_top_fault (
		.report_n(fault_n_w[2:0]),
		.group_n (top_group_fault_n)
	);

	gfm_and3 u_bot_fault (
		.report_n(fault_n_w[5:3]),
		.group_n (bottom_group_fault_n)
	);

	gfm_and3 u_top_oc (
		.report_n(oc_n_w[2:0]),
		.group_n (top_group_overcurrent_n)
	);

	gfm_and3 u_bot_oc (
		.report_n(oc_n_w[5:3]),
		.group_n (bottom_group_overcurrent_n)
	);

	// four independent group views, reported active high
	assign group_w = {~bottom_group_overcurrent_n, ~top_group_overcurrent_n,
	                  ~bottom_group_fault_n, ~top_group_fault_n}; // [R3]

	// zero-wait slave; read data is captured in the setup cycle
	assign pready = 1'b1;

	always @* begin
		rd_next  = 32'h00000000;
		err_next = 1'b0;
		case (paddr)
			`GFM_OFF_CTRL: begin
				rd_next[5:0] = ctrl_reg;
			end
			`GFM_OFF_OT_TRIP: begin
				rd_next[7:0] = ot_trip_reg;
			end
			`GFM_OFF_OT_HYST: begin
				rd_next[7:0] = ot_hyst_reg;
			end
			`GFM_OFF_STATUS: begin
				rd_next[`GFM_FLD_FAULT +: 6] = fault_w;
				rd_next[`GFM_FLD_OC +: 6]    = oc_w;
				rd_next[`GFM_FLD_OT +: 6]    = ot_w;
				rd_next[`GFM_FLD_GROUP +: 4] = group_w;
			end
			`GFM_OFF_EVENTS: begin
				rd_next[`GFM_FLD_FAULT +: 6] = ev_fault_reg;
				rd_next[`GFM_FLD_OC +: 6]    = ev_oc_reg;
				rd_next[`GFM_FLD_OT +: 6]    = ev_ot_reg;
			end
			`GFM_OFF_TEMP_LO: begin
				rd_next = junction_temp[31:0];
			end
			`GFM_OFF_TEMP_HI: begin
				rd_next[15:0] = junction_temp[47:32];
			end
			default: begin
				err_next = 1'b1;
			end
		endcase
	end

	// sticky rising-edge events; a new edge in the clearing cycle survives
	always @* begin
		ev_fault_next = ev_fault_reg & ~(clr_w1c & pwdata[`GFM_FLD_FAULT +: 6]);
		ev_oc_next    = ev_oc_reg & ~(clr_w1c & pwdata[`GFM_FLD_OC +: 6]);
		ev_ot_next    = ev_ot_reg & ~(clr_w1c & pwdata[`GFM_FLD_OT +: 6]);
		ev_fault_next = ev_fault_next | (fault_w & ~fault_d_reg);
		ev_oc_next    = ev_oc_next | (oc_w & ~oc_d_reg);
		ev_ot_next    = ev_ot_next | (ot_w & ~ot_d_reg);
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h00000000 : rd_next;
			pslverr <= err_next;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg    <= `GFM_CTRL_RST;
			ot_trip_reg <= `GFM_OT_TRIP_RST;
			ot_hyst_reg <= `GFM_OT_HYST_RST;
		end else if (wr_acc) begin
			case (paddr)
				`GFM_OFF_CTRL: begin
					ctrl_reg <= pwdata[5:0];
				end
				`GFM_OFF_OT_TRIP: begin
					ot_trip_reg <= pwdata[7:0]; // [R8]
				end
				`GFM_OFF_OT_HYST: begin
					ot_hyst_reg <= pwdata[7:0]; // [R8]
				end
				default: begin
					ctrl_reg <= ctrl_reg;
				end
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_d_reg  <= 6'h00;
			oc_d_reg     <= 6'h00;
			ot_d_reg     <= 6'h00;
			ev_fault_reg <= 6'h00;
			ev_oc_reg    <= 6'h00;
			ev_ot_reg    <= 6'h00;
		end else begin
			fault_d_reg  <= fault_w;
			oc_d_reg     <= oc_w;
			ot_d_reg     <= ot_w;
			ev_fault_reg <= ev_fault_next;
			ev_oc_reg    <= ev_oc_next;
			ev_ot_reg    <= ev_ot_next;
		end
	end

endmodule

//--- verif/gfm_monitor_sva.sv
// concurrent checks on the switch health block ports
module gfm_monitor_sva #(
	parameter int PWM_PERIOD = 5555
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [47:0] junction_temp,
	input wire logic [5:0]  overcurrent_guard,
	input wire logic [5:0]  short_circuit_guard,
	input wire logic [5:0]  supply_undervolt_lockout,
	input wire logic [5:0]  switch_fault_n,
	input wire logic [5:0]  switch_overcurrent_out_n,
	input wire logic [5:0]  temp_pin,
	input wire logic        top_group_fault_n,
	input wire logic        bottom_group_fault_n,
	input wire logic        top_group_overcurrent_n,
	input wire logic        bottom_group_overcurrent_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic prev_reg;
	logic armed_reg;
	int   hcnt_reg;
	int   pcnt_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= 1'b0;
			armed_reg <= 1'b0;
			hcnt_reg <= 0;
			pcnt_reg <= 0;
		end else begin
			prev_reg <= temp_pin[1];
			hcnt_reg <= temp_pin[1] ? hcnt_reg + 1 : 0;
			pcnt_reg <= (temp_pin[1] && !prev_reg) ? 1 : pcnt_reg + 1;
			if (temp_pin[1] && !prev_reg) begin
				armed_reg <= 1'b1;
			end
		end
	end
	// trip 175 and margin 20 assumed left at reset values
	sequence s_hot;
		junction_temp[39:32] >= 8'hAF;
	endsequence
	sequence s_warm;
		junction_temp[39:32] >= 8'h9B;
	endsequence
	a_group_and: assert property ({top_group_fault_n, bottom_group_fault_n, top_group_overcurrent_n,
		bottom_group_overcurrent_n} == {&switch_fault_n[2:0], &switch_fault_n[5:3],
		&switch_overcurrent_out_n[2:0], &switch_overcurrent_out_n[5:3]}) else $error("group level wrong");
	a_oc_report: assert property (switch_overcurrent_out_n ==
		~$past(overcurrent_guard | short_circuit_guard)) else $error("overcurrent report wrong");
	a_fault_report: assert property ((switch_fault_n &
		$past(supply_undervolt_lockout | short_circuit_guard)) == 6'h00) else $error("fault report missing");
	a_ot_pin: assert property (s_hot [*3] |-> temp_pin[4]) else $error("pin not held high");
	a_ot_hyst: assert property (s_hot ##1 s_warm [*3] |-> temp_pin[4]) else $error("fault cleared early");
	a_pwm_period: assert property ($rose(temp_pin[1]) && armed_reg |->
		pcnt_reg == PWM_PERIOD) else $error("carrier period wrong");
	a_duty_level: assert property ($fell(temp_pin[1]) |-> hcnt_reg ==
		PWM_PERIOD * (3750 + (junction_temp[15:8] - 25) * 790) / 125000) else $error("duty wrong");
endmodule

bind gfm_monitor gfm_monitor_sva #(.PWM_PERIOD(PWM_PERIOD)) u_sva (.pclk, .presetn, .junction_temp,
	.overcurrent_guard, .short_circuit_guard, .supply_undervolt_lockout, .switch_fault_n,
	.switch_overcurrent_out_n, .temp_pin, .top_group_fault_n, .bottom_group_fault_n,
	.top_group_overcurrent_n, .bottom_group_overcurrent_n);

//--- verif/gfm_ctrl_model.sv
// controller-side model: watches the groups and the phase v temperature pins
module gfm_ctrl_model #(
	parameter int PERIOD        = 5555,
	parameter int CAL_OFFSET_MV = 0,
	parameter int CAL_GAIN_PM   = 1000
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       top_group_fault_n,
	input  wire logic       bottom_group_fault_n,
	input  wire logic       top_group_overcurrent_n,
	input  wire logic       bottom_group_overcurrent_n,
	input  wire logic       phase_v_upper_temp,
	input  wire logic       phase_v_lower_temp,
	output logic      [3:0] group_seen,
	output logic      [7:0] upper_temp_c,
	output logic      [7:0] lower_temp_c,
	output wire logic       upper_ot,
	output wire logic       lower_ot
);
	timeunit 1ns;
	timeprecision 1ps;
	int up_cnt;
	int lo_cnt;
	int win_cnt;
	int up_hi;
	int lo_hi;
	// averaged level in millivolts at a 3.3 V swing, trimmed, then mapped to degrees
	function automatic logic [7:0] to_deg(input int hi);
		int mv;
		mv = hi * 3300 / PERIOD + CAL_OFFSET_MV;
		return 8'((mv - 99) * 125 * CAL_GAIN_PM / (2607 * 1000) + 25);
	endfunction
	// every clock is one oversample; a window of one carrier period stands in for the filter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_cnt <= 0;
			up_hi <= 0;
			lo_hi <= 0;
			upper_temp_c <= 8'h00;
			lower_temp_c <= 8'h00;
		end else if (win_cnt == PERIOD - 1) begin
			win_cnt <= 0;
			up_hi <= 0;
			lo_hi <= 0;
			upper_temp_c <= to_deg(up_hi + phase_v_upper_temp);
			lower_temp_c <= to_deg(lo_hi + phase_v_lower_temp);
		end else begin
			win_cnt <= win_cnt + 1;
			up_hi <= up_hi + phase_v_upper_temp;
			lo_hi <= lo_hi + phase_v_lower_temp;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_cnt <= 0;
			lo_cnt <= 0;
			group_seen <= 4'h0;
		end else begin
			up_cnt <= phase_v_upper_temp ? up_cnt + 1 : 0;
			lo_cnt <= phase_v_lower_temp ? lo_cnt + 1 : 0;
			group_seen <= group_seen | ~{top_group_fault_n, bottom_group_fault_n,
				top_group_overcurrent_n, bottom_group_overcurrent_n};
		end
	end
	// three missing falls: slow to flag, but immune to a single long pulse
	assign upper_ot = up_cnt > 3 * PERIOD;
	assign lower_ot = lo_cnt > 3 * PERIOD;
endmodule

//--- verif/gfm_monitor_test.sv
// testbench: apb register access, fault groups and temperature pulse trains
module gfm_monitor_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 100;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, upper_ot, lower_ot;
	logic [47:0] junction_temp = 48'h3C963CAA1928;
	logic [5:0]  overcurrent_guard = 6'h00, short_circuit_guard = 6'h00, supply_undervolt_lockout = 6'h00;
	logic [5:0]  switch_fault_n, switch_overcurrent_out_n, temp_pin;
	logic [3:0]  group_seen;
	logic [7:0]  upper_temp_c, lower_temp_c;
	logic        top_group_fault_n, bottom_group_fault_n, top_group_overcurrent_n, bottom_group_overcurrent_n;
	logic        phase_v_upper_temp, phase_v_lower_temp;
	int          bad_count = 0, samples_checked = 0, n;
	always #10 pclk = ~pclk;
	gfm_monitor #(.PWM_PERIOD(P)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .junction_temp, .overcurrent_guard, .short_circuit_guard, .supply_undervolt_lockout,
		.switch_fault_n, .switch_overcurrent_out_n, .temp_pin, .phase_v_upper_temp, .phase_v_lower_temp,
		.top_group_fault_n, .bottom_group_fault_n, .top_group_overcurrent_n, .bottom_group_overcurrent_n);
	gfm_ctrl_model #(.PERIOD(P)) mon (.pclk, .presetn, .top_group_fault_n, .bottom_group_fault_n,
		.top_group_overcurrent_n, .bottom_group_overcurrent_n, .phase_v_upper_temp, .phase_v_lower_temp,
		.group_seen, .upper_ot, .lower_ot, .upper_temp_c, .lower_temp_c);
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// high cycles over one carrier period, counted between edges
	task automatic hc(input int i);
		n = 0;
		repeat (P) begin
			@(negedge pclk);
			n += (temp_pin[i] === 1'b1);
		end
		@(posedge pclk);
	endtask
	function automatic int h(input int t);
		return P * (3750 + (t - 25) * 790) / 125000;
	endfunction
	task automatic end_sim;
		if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		end_sim;
	end
	initial begin
		cyc(12);
		presetn <= 1'b1;
		apb(0, 12'h004, 0);
		chk("trip", rd, 32'hAF);
		apb(0, 12'h01C, 0);
		chk("unmapped", er, 1);
		overcurrent_guard <= 6'h04;
		supply_undervolt_lockout <= 6'h20;
		cyc(3);
		chk("groups", {bottom_group_fault_n, top_group_overcurrent_n, bottom_group_overcurrent_n}, 3'b001);
		apb(0, 12'h00C, 0);
		chk("status", rd, 32'h07000424);
		overcurrent_guard <= 6'h00;
		supply_undervolt_lockout <= 6'h00;
		short_circuit_guard <= 6'h08;
		cyc(3);
		chk("short", {bottom_group_fault_n, top_group_fault_n, bottom_group_overcurrent_n}, 3'b010);
		short_circuit_guard <= 6'h00;
		apb(1, 12'h000, 1);
		cyc(3);
		chk("forced", {switch_fault_n, top_group_fault_n}, 7'h7C);
		apb(1, 12'h000, 0);
		cyc(2 * P);
		hc(1);
		chk("duty25", n, h(25));
		hc(4);
		chk("duty150", n, h(150));
		hc(2);
		chk("duty170", n, h(170));
		junction_temp[39:32] <= 8'hB4;
		cyc(3);
		hc(4);
		chk("ot_high", n, P);
		cyc(3 * P);
		chk("ot_seen", {lower_ot, upper_ot, switch_fault_n[4]}, 3'b100);
		junction_temp[39:32] <= 8'hA0;
		cyc(2);
		hc(4);
		chk("ot_hold", n, P);
		junction_temp[39:32] <= 8'h96;
		cyc(2 * P);
		hc(4);
		chk("ot_clear", n, h(150));
		chk("ot_off", lower_ot, 0);
		chk("lower_deg", lower_temp_c, 32'h96);
		chk("upper_deg", upper_temp_c, 32'h19);
		chk("seen", group_seen, 4'hF);
		apb(0, 12'h008, 0);
		chk("hyst", rd, 32'h14);
		apb(0, 12'h010, 0);
		chk("events", rd, 32'h00100C3D);
		chk("events_err", er, 0);
		apb(1, 12'h010, 32'h003F3F3F);
		apb(0, 12'h010, 0);
		chk("events_clr", rd, 32'h00000000);
		end_sim;
	end
endmodule
